// ==== hw/opst_event_bank.sv ====
// Bank of sticky event bits, one for each status sub-register.
// Assumes set and clear come from the clock domain of sys_clk_i; a set may be held high as a level.
module opst_event_bank #(
   parameter int unsigned N = 6
) (
   // Clock and reset
   input  wire logic     sys_clk_i,
   input  wire logic     rst_b_i,
   // Event requests and held bits
   opst_evt_if.bank      evt_if
);

   logic [N-1:0] evt;
   logic [N-1:0] next_evt;

   // A set arriving with its clear survives, so no start or stop is lost to a query.
   always_comb begin
      next_evt = evt_if.set | (evt & ~evt_if.clr);
   end

   // Held event bits.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         evt <= '0;
      end else begin
         evt <= next_evt;
      end
   end

   assign evt_if.evt = evt;

endmodule

// ==== hw/opst_evt_if.sv ====
// Interface between the status top and its sticky event bank.
// Assumes both ends run on the same clock; carries set, clear and held bits.
interface opst_evt_if #(
   parameter int unsigned N = 6
);
   logic [N-1:0] set;
   logic [N-1:0] clr;
   logic [N-1:0] evt;

   modport bank (input set, input clr, output evt);
   modport user (output set, output clr, input evt);
endinterface

// ==== hw/opst_pkg.sv ====
// Package of the operation status tree: bit positions, query codes and timing.
// Assumes one 250 MHz clock; shared by the top and the verif models, while the event bank takes only its width N.
package opst_pkg;

   // --------------------
   // Register geometry
   // --------------------
   localparam int unsigned REG_W        = 16;
   localparam int unsigned NUM_SUB      = 6;
   localparam int unsigned SUB_ACT_BIT  = 1;    // Only live bit of every sub-register.

   // Sub-register index inside the event bank.
   localparam int unsigned SUB_CAL      = 0;
   localparam int unsigned SUB_MEAS     = 1;
   localparam int unsigned SUB_TRIG     = 2;
   localparam int unsigned SUB_SENSE    = 3;
   localparam int unsigned SUB_LLF      = 4;
   localparam int unsigned SUB_ULF      = 5;

   // Summary bit positions in the top operation register.
   localparam int unsigned SUM_CAL_BIT   = 0;
   localparam int unsigned SUM_MEAS_BIT  = 4;
   localparam int unsigned SUM_TRIG_BIT  = 5;
   localparam int unsigned SUM_SENSE_BIT = 10;
   localparam int unsigned SUM_LLF_BIT   = 11;
   localparam int unsigned SUM_ULF_BIT   = 12;

   // --------------------
   // Status query codes
   // --------------------
   localparam int unsigned QRY_W = 4;
   localparam logic [3:0] QRY_OPER_COND  = 4'h0;
   localparam logic [3:0] QRY_OPER_EVENT = 4'h1;
   localparam logic [3:0] QRY_CAL_COND   = 4'h2;
   localparam logic [3:0] QRY_CAL_EVENT  = 4'h3;
   localparam logic [3:0] QRY_MEAS_COND  = 4'h4;
   localparam logic [3:0] QRY_MEAS_EVENT = 4'h5;
   localparam logic [3:0] QRY_TRIG_COND  = 4'h6;
   localparam logic [3:0] QRY_TRIG_EVENT = 4'h7;
   localparam logic [3:0] QRY_SNS_COND   = 4'h8;
   localparam logic [3:0] QRY_SNS_EVENT  = 4'h9;
   localparam logic [3:0] QRY_LLF_COND   = 4'ha;
   localparam logic [3:0] QRY_LLF_EVENT  = 4'hb;
   localparam logic [3:0] QRY_ULF_COND   = 4'hc;
   localparam logic [3:0] QRY_ULF_EVENT  = 4'hd;

   // --------------------
   // Timing
   // --------------------
   localparam int unsigned CLK_MHZ      = 250;
   localparam int unsigned INIT_TIME_NS = 10000;
   localparam int unsigned INIT_CYCLES  = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned VALUE_W      = 16;

   // Activity sequencer states.
   typedef enum logic [2:0] {
      OPST_INIT,
      OPST_IDLE,
      OPST_CAL,
      OPST_WAIT_TRIG,
      OPST_MEAS
   } opst_state_t;

endpackage

// ==== hw/opst_top.sv ====
// Operation status tree of a power sensor: six sub-registers and their summary word.
// Assumes all inputs are synchronous to sys_clk_i and that the host polls by status queries.
//
// Behaviour
// R1: Operation bit 0 summarises the calibrating sub-register.
// R2: Operation bit 4 summarises the measuring sub-register.
// R3: Operation bit 5 summarises the trigger-wait sub-register.
// R4: Operation bit 10 summarises the initialization sub-register.
// R5: Operation bit 11 summarises the lower limit violation sub-register.
// R6: Operation bit 12 summarises the upper limit violation sub-register.
// R7: Calibration condition bit 1 is high while calibrating.
// R8: Calibration event latches any calibration start or finish since last read.
// R9: Measurement condition bit 1 is high while measuring.
// R10: Measurement event latches any measurement start or finish since last read.
// R11: Trigger-wait condition bit 1 is high while awaiting a trigger.
// R12: An arriving trigger moves the sensor from waiting into measuring.
// R13: Trigger-wait event records any waiting since last read.
// R14: Initialization condition bit 1 is high while initializing.
// R15: Initialize at power-up, on connection, on reset and on preset commands.
// R16: Initialization event latches any initialization start or finish since last read.
// R17: Lower limit condition bit 1 is high while value is below lower limit.
// R18: Lower limit event records any value below the limit since last read.
// R19: Upper limit condition bit 1 is high while value exceeds upper limit.
// R20: Every unused sub-register bit reads zero; bit 1 alone is live.
// R21: Each summary bit is the OR of its sub-register event bits.
module opst_top #(
   parameter int unsigned VALUE_W     = opst_pkg::VALUE_W,
   parameter int unsigned INIT_CYCLES = opst_pkg::INIT_CYCLES
) (
   // Clock and reset
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_b_i,
   // Initialization causes
   input  wire logic                       connect_i,
   input  wire logic                       rst_cmd_i,
   input  wire logic                       preset_cmd_i,
   // Calibration and measurement control
   input  wire logic                       cal_start_i,
   input  wire logic                       cal_done_i,
   input  wire logic                       arm_i,
   input  wire logic                       trigger_i,
   input  wire logic                       meas_done_i,
   // Measured value and limits
   input  wire logic                       value_valid_i,
   input  wire logic [VALUE_W-1:0]         value_i,
   input  wire logic [VALUE_W-1:0]         lower_limit_i,
   input  wire logic [VALUE_W-1:0]         upper_limit_i,
   // Status query port
   input  wire logic                       query_valid_i,
   input  wire logic [opst_pkg::QRY_W-1:0] query_code_i,
   output logic                            answer_valid_o,
   output logic [opst_pkg::REG_W-1:0]      answer_data_o,
   // Live summary word
   output logic [opst_pkg::REG_W-1:0]      op_summary_o
);

   // --------------------
   // Helpers
   // Functions shared by the answer mux.
   // They hold no state.
   // --------------------

   // Places one activity flag on its only live bit; the other fifteen read zero.
   function automatic logic [opst_pkg::REG_W-1:0] sub_word(input logic flag);
      logic [opst_pkg::REG_W-1:0] w;
      w = '0;
      w[opst_pkg::SUB_ACT_BIT] = flag; // [R20]
      return w;
   endfunction

   // --------------------
   // Activity sequencer
   // Init, idle, calibrate, wait, measure.
   // Init requests win over all else.
   // --------------------

   localparam int unsigned CNT_W = $clog2(INIT_CYCLES + 1);
   localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);

   opst_pkg::opst_state_t state;
   opst_pkg::opst_state_t next_state;
   logic [CNT_W-1:0]      init_cnt;
   logic [CNT_W-1:0]      next_init_cnt;
   logic                  init_req;

   // Any of the three causes restarts initialization, aborting whatever runs.
   assign init_req = connect_i | rst_cmd_i | preset_cmd_i; // [R15]

   // Next state and initialization timer.
   always_comb begin
      next_state    = state;
      next_init_cnt = init_cnt;
      if (init_req) begin
         next_state    = opst_pkg::OPST_INIT; // [R15]
         next_init_cnt = '0;
      end else begin
         unique case (state)
            opst_pkg::OPST_INIT: begin
               if (init_cnt == INIT_LAST) begin
                  next_state = opst_pkg::OPST_IDLE;
               end else begin
                  next_init_cnt = init_cnt + CNT_W'(1);
               end
            end
            opst_pkg::OPST_IDLE: begin
               // Calibration takes precedence when both arrive together.
               if (cal_start_i) begin
                  next_state = opst_pkg::OPST_CAL;
               end else if (arm_i) begin
                  next_state = opst_pkg::OPST_WAIT_TRIG;
               end
            end
            opst_pkg::OPST_CAL: begin
               if (cal_done_i) begin
                  next_state = opst_pkg::OPST_IDLE;
               end
            end
            opst_pkg::OPST_WAIT_TRIG: begin
               if (trigger_i) begin
                  next_state = opst_pkg::OPST_MEAS; // [R12]
               end
            end
            opst_pkg::OPST_MEAS: begin
               if (meas_done_i) begin
                  next_state = opst_pkg::OPST_IDLE;
               end
            end
            default: begin
               next_state = opst_pkg::OPST_INIT;
            end
         endcase
      end
   end

   // Reset drops straight into initialization, which is the power-up case.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state    <= opst_pkg::OPST_INIT; // [R15]
         init_cnt <= '0;
      end else begin
         state    <= next_state;
         init_cnt <= next_init_cnt;
      end
   end

   // --------------------
   // Condition bits
   // Live levels of the six activities.
   // Limit flags move only on new values.
   // --------------------

   logic [opst_pkg::NUM_SUB-1:0] cond;
   logic [opst_pkg::NUM_SUB-1:0] prev_cond;
   logic                         below_low;
   logic                         above_high;
   logic                         next_below_low;
   logic                         next_above_high;

   // Limit comparisons only change when a fresh value arrives.
   always_comb begin
      next_below_low  = below_low;
      next_above_high = above_high;
      if (value_valid_i) begin
         next_below_low  = value_i < lower_limit_i; // [R17]
         next_above_high = value_i > upper_limit_i; // [R19]
      end
   end

   // Limit flags; a value held in reset is not trusted, so both start clear.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         below_low  <= 1'b0;
         above_high <= 1'b0;
      end else begin
         below_low  <= next_below_low;
         above_high <= next_above_high;
      end
   end

   // Live conditions, straight from the registered state and flags.
   always_comb begin
      cond                         = '0;
      cond[opst_pkg::SUB_CAL]      = state == opst_pkg::OPST_CAL;       // [R7]
      cond[opst_pkg::SUB_MEAS]     = state == opst_pkg::OPST_MEAS;      // [R9]
      cond[opst_pkg::SUB_TRIG]     = state == opst_pkg::OPST_WAIT_TRIG; // [R11]
      cond[opst_pkg::SUB_SENSE]    = state == opst_pkg::OPST_INIT;      // [R14]
      cond[opst_pkg::SUB_LLF]      = below_low;                         // [R17]
      cond[opst_pkg::SUB_ULF]      = above_high;                        // [R19]
   end

   // Previous conditions for start and finish detection.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_cond <= '0;
      end else begin
         prev_cond <= cond;
      end
   end

   // --------------------
   // Event bank
   // Sticky bits, cleared by event reads.
   // A set always beats a clear.
   // --------------------

   opst_evt_if #(.N(opst_pkg::NUM_SUB)) evt_if ();

   logic clr_cal;
   logic clr_meas;
   logic clr_trig;
   logic clr_sense;
   logic clr_llf;
   logic clr_ulf;

   // A read of an event word clears it in the same cycle as the answer is taken.
   assign clr_cal   = query_valid_i && query_code_i == opst_pkg::QRY_CAL_EVENT;
   assign clr_meas  = query_valid_i && query_code_i == opst_pkg::QRY_MEAS_EVENT;
   assign clr_trig  = query_valid_i && query_code_i == opst_pkg::QRY_TRIG_EVENT;
   assign clr_sense = query_valid_i && query_code_i == opst_pkg::QRY_SNS_EVENT;
   assign clr_llf   = query_valid_i && query_code_i == opst_pkg::QRY_LLF_EVENT;
   assign clr_ulf   = query_valid_i && query_code_i == opst_pkg::QRY_ULF_EVENT;

   // Activities latch both edges; waiting and limit faults latch their level.
   always_comb begin
      evt_if.set                     = '0;
      evt_if.set[opst_pkg::SUB_CAL]  = cond[opst_pkg::SUB_CAL] != prev_cond[opst_pkg::SUB_CAL];     // [R8]
      evt_if.set[opst_pkg::SUB_MEAS] = cond[opst_pkg::SUB_MEAS] != prev_cond[opst_pkg::SUB_MEAS];   // [R10]
      evt_if.set[opst_pkg::SUB_TRIG] = cond[opst_pkg::SUB_TRIG];                                   // [R13]
      evt_if.set[opst_pkg::SUB_SENSE] = cond[opst_pkg::SUB_SENSE] != prev_cond[opst_pkg::SUB_SENSE]; // [R16]
      evt_if.set[opst_pkg::SUB_LLF]  = cond[opst_pkg::SUB_LLF];                                    // [R18]
      evt_if.set[opst_pkg::SUB_ULF]  = cond[opst_pkg::SUB_ULF];
   end

   // Clear requests gathered into the bank's vector.
   always_comb begin
      evt_if.clr                      = '0;
      evt_if.clr[opst_pkg::SUB_CAL]   = clr_cal;
      evt_if.clr[opst_pkg::SUB_MEAS]  = clr_meas;
      evt_if.clr[opst_pkg::SUB_TRIG]  = clr_trig;
      evt_if.clr[opst_pkg::SUB_SENSE] = clr_sense;
      evt_if.clr[opst_pkg::SUB_LLF]   = clr_llf;
      evt_if.clr[opst_pkg::SUB_ULF]   = clr_ulf;
   end

   // Sticky bits; a set in the clearing cycle wins inside the bank.
   opst_event_bank #(
      .N         (opst_pkg::NUM_SUB)
   ) u_event_bank (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .evt_if    (evt_if.bank)
   );

   // --------------------
   // Summary word
   // One bit for each sub-register.
   // Registered for the live output.
   // --------------------

   logic [opst_pkg::REG_W-1:0] summary;
   logic [opst_pkg::REG_W-1:0] summary_q;

   // Each sub-register has one live event bit, so its OR is that bit.
   always_comb begin
      summary                          = '0;
      summary[opst_pkg::SUM_CAL_BIT]   = |sub_word(evt_if.evt[opst_pkg::SUB_CAL]);   // [R1] [R21]
      summary[opst_pkg::SUM_MEAS_BIT]  = |sub_word(evt_if.evt[opst_pkg::SUB_MEAS]);  // [R2] [R21]
      summary[opst_pkg::SUM_TRIG_BIT]  = |sub_word(evt_if.evt[opst_pkg::SUB_TRIG]);  // [R3] [R21]
      summary[opst_pkg::SUM_SENSE_BIT] = |sub_word(evt_if.evt[opst_pkg::SUB_SENSE]); // [R4] [R21]
      summary[opst_pkg::SUM_LLF_BIT]   = |sub_word(evt_if.evt[opst_pkg::SUB_LLF]);   // [R5] [R21]
      summary[opst_pkg::SUM_ULF_BIT]   = |sub_word(evt_if.evt[opst_pkg::SUB_ULF]);   // [R6] [R21]
   end

   // Registered copy for the live output, one cycle behind the bank.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         summary_q <= '0;
      end else begin
         summary_q <= summary;
      end
   end

   assign op_summary_o = summary_q;

   // --------------------
   // Query answers
   // Registered answer to each query.
   // Unknown codes read as zero.
   // --------------------

   logic [opst_pkg::REG_W-1:0] next_answer;
   logic [opst_pkg::REG_W-1:0] answer;
   logic                       answer_vld;

   // The answer shows the word as it stood when the query was taken; the
   // event clear lands on the same edge, so the host never misses a bit.
   always_comb begin
      unique case (query_code_i)
         opst_pkg::QRY_OPER_COND:  next_answer = summary;
         opst_pkg::QRY_OPER_EVENT: next_answer = summary;
         opst_pkg::QRY_CAL_COND:   next_answer = sub_word(cond[opst_pkg::SUB_CAL]);
         opst_pkg::QRY_CAL_EVENT:  next_answer = sub_word(evt_if.evt[opst_pkg::SUB_CAL]);
         opst_pkg::QRY_MEAS_COND:  next_answer = sub_word(cond[opst_pkg::SUB_MEAS]);
         opst_pkg::QRY_MEAS_EVENT: next_answer = sub_word(evt_if.evt[opst_pkg::SUB_MEAS]);
         opst_pkg::QRY_TRIG_COND:  next_answer = sub_word(cond[opst_pkg::SUB_TRIG]);
         opst_pkg::QRY_TRIG_EVENT: next_answer = sub_word(evt_if.evt[opst_pkg::SUB_TRIG]);
         opst_pkg::QRY_SNS_COND:   next_answer = sub_word(cond[opst_pkg::SUB_SENSE]);
         opst_pkg::QRY_SNS_EVENT:  next_answer = sub_word(evt_if.evt[opst_pkg::SUB_SENSE]);
         opst_pkg::QRY_LLF_COND:   next_answer = sub_word(cond[opst_pkg::SUB_LLF]);
         opst_pkg::QRY_LLF_EVENT:  next_answer = sub_word(evt_if.evt[opst_pkg::SUB_LLF]);
         opst_pkg::QRY_ULF_COND:   next_answer = sub_word(cond[opst_pkg::SUB_ULF]);
         opst_pkg::QRY_ULF_EVENT:  next_answer = sub_word(evt_if.evt[opst_pkg::SUB_ULF]);
         default:                  next_answer = '0; // Unknown codes answer zero.
      endcase
   end

   // Answer data hold until the next query; the strobe copies query_valid_i one cycle later.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         answer     <= '0;
         answer_vld <= 1'b0;
      end else begin
         answer_vld <= query_valid_i;
         if (query_valid_i) begin
            answer <= next_answer;
         end
      end
   end

   assign answer_valid_o = answer_vld;
   assign answer_data_o  = answer;

endmodule

// ==== verif/opst_host_model.sv ====
// Remote host model that issues one status query at a time and collects the answer.
// Assumes the query port of opst_top and a bench that calls ask from its falling-edge driver.
module opst_host_model (
   // Clock
   input  wire logic                       sys_clk_i,
   // Answer from the sensor
   input  wire logic                       answer_valid_i,
   input  wire logic [opst_pkg::REG_W-1:0] answer_data_i,
   // Query strobe and code
   output logic                            query_valid_o,
   output logic [opst_pkg::QRY_W-1:0]      query_code_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // The strobe is idle from time zero.
   initial begin
      query_valid_o = 1'b0;
      query_code_o  = 4'h0;
   end

   // One-cycle strobe, then the code is scrambled so a stale code can never look valid.
   task automatic ask(input logic [3:0] code, input int gap, output logic [15:0] data);
      int n = 0;
      data = 16'hxxxx;
      repeat (gap) @(negedge sys_clk_i);
      @(negedge sys_clk_i);
      query_valid_o = 1'b1;
      query_code_o  = code;
      @(negedge sys_clk_i);
      query_valid_o = 1'b0;
      query_code_o  = ~code;
      while (answer_valid_i !== 1'b1 && n < 4) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (answer_valid_i === 1'b1) data = answer_data_i;
   endtask
endmodule

// ==== verif/opst_top_bench.sv ====
// Self-checking bench of opst_top against an integer model of the status tree.
// Assumes opst_host_model as the query master and the bound checker beside the top.
module opst_top_bench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int unsigned INIT_N = 40;
   localparam int unsigned POS[6] = '{opst_pkg::SUM_CAL_BIT, opst_pkg::SUM_MEAS_BIT, opst_pkg::SUM_TRIG_BIT,
                                      opst_pkg::SUM_SENSE_BIT, opst_pkg::SUM_LLF_BIT, opst_pkg::SUM_ULF_BIT};
   logic        sys_clk_i     = 1'b0;
   logic        rst_b_i       = 1'b0;
   logic [7:0]  ctl           = 8'h00;
   logic        value_valid_i = 1'b0;
   logic [15:0] value_i       = 16'h0000;
   logic [15:0] lower_i       = 16'h0000;
   logic [15:0] upper_i       = 16'h0000;
   logic        query_valid_i;
   logic [3:0]  query_code_i;
   logic        answer_valid_o;
   logic [15:0] answer_data_o;
   logic [15:0] op_summary_o;
   int          err_count     = 0;
   int          comparisons   = 0;
   int          st            = 0;
   bit          cnd[6];
   bit          evt[6];

   // Free-running 250 MHz clock.
   always #2 sys_clk_i = ~sys_clk_i;

   // Controls in ctl: connect, reset cmd, preset, cal start, cal done, arm, trigger, meas done.
   opst_top #(.INIT_CYCLES(INIT_N)) i_opst_top (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .connect_i(ctl[0]),
      .rst_cmd_i(ctl[1]), .preset_cmd_i(ctl[2]), .cal_start_i(ctl[3]), .cal_done_i(ctl[4]), .arm_i(ctl[5]),
      .trigger_i(ctl[6]), .meas_done_i(ctl[7]), .value_valid_i(value_valid_i), .value_i(value_i),
      .lower_limit_i(lower_i), .upper_limit_i(upper_i), .query_valid_i(query_valid_i),
      .query_code_i(query_code_i), .answer_valid_o(answer_valid_o), .answer_data_o(answer_data_o),
      .op_summary_o(op_summary_o));
   opst_host_model i_opst_host_model (.sys_clk_i(sys_clk_i), .answer_valid_i(answer_valid_o),
      .answer_data_i(answer_data_o), .query_valid_o(query_valid_i), .query_code_o(query_code_i));

   // Summary word of the model: one bit for each sticky sub-register event.
   function automatic logic [15:0] summ();
      logic [15:0] s;
      s = 16'h0000;
      for (int k = 0; k < 6; k++) if (evt[k]) s[POS[k]] = 1'b1;
      return s;
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Event reads clear; level events return while their condition holds.
   task automatic query(input logic [3:0] c, input int gap);
      logic [15:0] d;
      logic [15:0] e;
      int          k;
      k = int'(c) / 2 - 1;
      e = 16'h0000;
      if (c <= 4'h1) e = summ();
      else if (c <= 4'hd) e = (c[0] ? evt[k] : cnd[k]) ? 16'h0002 : 16'h0000;
      i_opst_host_model.ask(c, gap, d);
      check(d, e);
      if (c[0] && c >= 4'h3 && c <= 4'hd) evt[k] = (k == 2 || k >= 4) ? cnd[k] : 1'b0;
      repeat (3) @(negedge sys_clk_i);
      check(op_summary_o, summ());
   endtask

   // Init requests block until initialization ends, so no query lands in it.
   task automatic act(input int k);
      @(negedge sys_clk_i) ctl[k] = 1'b1;
      @(negedge sys_clk_i) ctl = 8'h00;
      if (k <= 2) begin
         if (st == 2 || st == 4) evt[st / 2 - 1] = 1'b1;
         for (int j = 0; j < 4; j++) cnd[j] = (j == 3);
         evt[3] = 1'b1;
         repeat (INIT_N + 2) @(negedge sys_clk_i);
         cnd[3] = 1'b0;
         st = 1;
      end
      if (k == 3 && st == 1) begin st = 2; cnd[0] = 1'b1; evt[0] = 1'b1; end
      else if (k == 4 && st == 2) begin st = 1; cnd[0] = 1'b0; evt[0] = 1'b1; end
      else if (k == 5 && st == 1) begin st = 3; cnd[2] = 1'b1; evt[2] = 1'b1; end
      else if (k == 6 && st == 3) begin st = 4; cnd[2] = 1'b0; cnd[1] = 1'b1; evt[1] = 1'b1; end
      else if (k == 7 && st == 4) begin st = 1; cnd[1] = 1'b0; evt[1] = 1'b1; end
      repeat (3) @(negedge sys_clk_i);
   endtask

   // A new value with fresh limits, then the lower-limit condition is read.
   task automatic new_value();
      @(negedge sys_clk_i);
      value_valid_i = 1'b1;
      value_i = 16'($urandom);
      lower_i = 16'($urandom);
      upper_i = 16'($urandom);
      @(negedge sys_clk_i);
      value_valid_i = 1'b0;
      cnd[4] = value_i < lower_i;
      cnd[5] = value_i > upper_i;
      evt[4] |= cnd[4];
      evt[5] |= cnd[5];
      value_i = ~value_i;
      query(4'ha, 0);
   endtask

   task automatic reset_dut();
      rst_b_i = 1'b0;
      repeat (16) @(negedge sys_clk_i);
      st = 0;
      cnd = '{default: 1'b0};
      evt = '{default: 1'b0};
      cnd[3] = 1'b1;
      evt[3] = 1'b1;
      rst_b_i = 1'b1;
      query(4'h8, 0);
      repeat (INIT_N) @(negedge sys_clk_i);
      cnd[3] = 1'b0;
      st = 1;
   endtask

   // Main sequence: random traffic, every query code, then a closing reset.
   initial begin
      int r;
      void'($urandom(97));
      reset_dut();
      for (int i = 0; i < 300; i++) begin
         r = $urandom_range(11, 0);
         if (r == 0) act($urandom_range(2, 0));
         else if (r <= 5) act(r + 2);
         else if (r <= 8) new_value();
         else query(4'($urandom_range(15, 0)), $urandom_range(2, 0));
      end
      for (int c = 0; c < 16; c++) query(4'(c), 0);
      reset_dut();
      summarize();
   end

   // Watchdog well beyond the expected run length.
   initial begin
      #240000;
      err_count++;
      summarize();
   end
endmodule

// ==== verif/opst_top_monitor.sv ====
// Checker of the operation status tree, seeing only the ports of opst_top.
// Assumes one clock domain and the active-low asynchronous reset of the top.
module opst_top_monitor #(
   parameter int unsigned VALUE_W     = 16,
   parameter int unsigned INIT_CYCLES = 8
) (
   // Clock and reset
   input wire logic                       sys_clk_i,
   input wire logic                       rst_b_i,
   // Measured value and limit
   input wire logic                       value_valid_i,
   input wire logic [VALUE_W-1:0]         value_i,
   input wire logic [VALUE_W-1:0]         lower_limit_i,
   // Query port and summary
   input wire logic                       query_valid_i,
   input wire logic [opst_pkg::QRY_W-1:0] query_code_i,
   input wire logic                       answer_valid_o,
   input wire logic [opst_pkg::REG_W-1:0] answer_data_o,
   input wire logic [opst_pkg::REG_W-1:0] op_summary_o
);
   logic [7:0] cnt;
   logic [7:0] next_cnt;

   // --------------------
   // Cycles since reset release
   // --------------------
   // Saturates, so long runs never wrap into the start-up window.
   always_comb next_cnt = (cnt == 8'hff) ? cnt : cnt + 8'h01;

   // Registers the cycle count.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) cnt <= 8'h00;
      else cnt <= next_cnt;
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   // --------------------
   // Properties
   // --------------------
   sequence s_below;
      value_valid_i && (value_i < lower_limit_i);
   endsequence
   sequence s_llf_ask;
      !value_valid_i ##1 (!value_valid_i && query_valid_i && query_code_i == opst_pkg::QRY_LLF_COND);
   endsequence

   property p_answer_pulse;
      query_valid_i |=> answer_valid_o ##1 (answer_valid_o == $past(query_valid_i));
   endproperty
   property p_answer_holds;
      !$past(query_valid_i) |-> $stable(answer_data_o);
   endproperty
   property p_sub_unused;
      answer_valid_o && $past(query_code_i) >= 4'h2 |-> (answer_data_o & 16'hfffd) == 16'h0000;
   endproperty
   property p_sum_unused;
      (op_summary_o & 16'he3ce) == 16'h0000;
   endproperty
   property p_unknown_code;
      query_valid_i && query_code_i >= 4'he |=> answer_data_o == 16'h0000;
   endproperty
   property p_sense_init;
      query_valid_i && query_code_i == opst_pkg::QRY_SNS_COND && cnt < INIT_CYCLES - 2 |=> answer_data_o == 16'h0002;
   endproperty
   property p_sense_sum;
      cnt == 8'h02 && !$past(query_valid_i, 2) |-> op_summary_o[10];
   endproperty
   property p_llf_cond;
      s_below ##1 s_llf_ask |=> answer_data_o == 16'h0002;
   endproperty

   a_answer_pulse: assert property (p_answer_pulse) else $error("answer strobe wrong");
   a_answer_holds: assert property (p_answer_holds) else $error("answer data moved without query");
   a_sub_unused: assert property (p_sub_unused) else $error("unused sub bit set");
   a_sum_unused: assert property (p_sum_unused) else $error("unused summary bit set");
   a_unknown_code: assert property (p_unknown_code) else $error("unknown code answered nonzero");
   a_sense_init: assert property (p_sense_init) else $error("not initializing after reset");
   a_sense_sum: assert property (p_sense_sum) else $error("sense summary missing");
   a_llf_cond: assert property (p_llf_cond) else $error("lower limit condition missing");
endmodule

bind opst_top opst_top_monitor #(.VALUE_W(VALUE_W), .INIT_CYCLES(INIT_CYCLES)) i_opst_top_monitor (
   .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .value_valid_i(value_valid_i), .value_i(value_i),
   .lower_limit_i(lower_limit_i), .query_valid_i(query_valid_i), .query_code_i(query_code_i),
   .answer_valid_o(answer_valid_o), .answer_data_o(answer_data_o), .op_summary_o(op_summary_o));
